// File: rtl/dac_aux_regs_defines.vh
// Register offsets, field positions, reset values for the aux/gain/error bank.
// Assumes inclusion by bare name from the register bank module files.
`ifndef DAC_AUX_REGS_DEFINES_VH
`define DAC_AUX_REGS_DEFINES_VH

// Register offsets (byte addresses on the internal register port)
`define AUX1_CTRL_HIGH_ADDR 8'h0e
`define QUAD_GAIN_LOW_ADDR 8'h0f
`define QUAD_GAIN_HIGH_ADDR 8'h10
`define AUX2_DATA_LOW_ADDR 8'h11
`define AUX2_CTRL_HIGH_ADDR 8'h12
`define TIMING_ERR_ADDR 8'h19

// Upper aux control register fields
`define AUX_SIGN_BIT 7
`define AUX_DIR_BIT 6
`define AUX_PD_BIT 5
`define DATA_HI_MSB 1

// Quadrature gain upper register fields
`define QUAD_SLEEP_BIT 7
`define QUAD_PD_BIT 6

// Timing error register fields
`define ERR_DATA_BIT 7
`define ERR_SYNC_BIT 6
`define ERR_TYPE_BIT 4
`define ERR_DATA_EN_BIT 3
`define ERR_SYNC_EN_BIT 2
`define SYNC_LOOP_BIT 0

// Reset values
`define AUX1_CTRL_HIGH_RST 8'h00
`define QUAD_GAIN_LOW_RST 8'hfc
`define QUAD_GAIN_HIGH_RST 8'h01
`define AUX2_DATA_LOW_RST 8'h00
`define AUX2_CTRL_HIGH_RST 8'h00
`define TIMING_ERR_RST 8'h00

// Writable-bit masks; all other bits ignore writes and read zero, except the error flags and type bit
`define AUX_CTRL_HIGH_MASK 8'he3
`define QUAD_GAIN_HIGH_MASK 8'hc3
`define TIMING_ERR_WMASK 8'h0d

`endif

// File: rtl/sticky_flag.v
// One latched event flag with a clear request; a set always beats a clear.
// Assumes set and clear are synchronous to clk_in.
`timescale 1ns/1ps
module sticky_flag (
    input wire clk_in,
    input wire rstn_in,
    input wire set_in,
    input wire clear_in,
    output reg flag_out
);

    // Flag holds until cleared; an event in the clear cycle is kept
    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_out <= 1'b0;
        end else if (set_in) begin
            flag_out <= 1'b1;
        end else if (clear_in) begin
            flag_out <= 1'b0;
        end
    end

endmodule // sticky_flag

// File: rtl/dac_aux_gain_irq_regs.v
// Configuration bank: aux current DAC 1/2 controls, quadrature DAC gain and
// power, and latched timing error flags with read-to-clear.
// Assumes the serial port front end delivers one-cycle read and write
// strobes with address and data, all synchronous to ref_clk_in.
`timescale 1ns/1ps
`include "dac_aux_regs_defines.vh"
module dac_aux_gain_irq_regs #(
    parameter DATA_WIDTH = 10
) (
    input wire ref_clk_in,
    input wire rstn_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire data_timing_err_in,
    input wire data_err_setup_in,
    input wire sync_timing_err_in,
    output reg [7:0] reg_rdata_out,
    output reg [DATA_WIDTH-1:0] quad_gain_out,
    output reg quad_sleep_out,
    output reg quad_pd_out,
    output reg [1:0] aux1_data_high_out,
    output reg aux1_pos_out,
    output reg aux1_neg_out,
    output reg aux1_sink_out,
    output reg aux1_pd_out,
    output reg [DATA_WIDTH-1:0] aux2_pos_out,
    output reg [DATA_WIDTH-1:0] aux2_neg_out,
    output reg aux2_sink_out,
    output reg aux2_pd_out,
    output reg sync_loopback_out,
    output reg timing_irq_out
);

    // Stored register images (only writable bits are ever nonzero)
    reg [7:0] aux_current1_ctrl_high; // Sign, direction, power-down, data 9:8
    reg [7:0] quad_gain_low; // Gain bits 7:0
    reg [7:0] quad_gain_high_power; // Sleep, power-down, gain 9:8
    reg [7:0] aux_current2_data_low; // Aux2 word bits 7:0
    reg [7:0] aux_current2_ctrl_high; // Sign, direction, power-down, data 9:8
    reg [7:0] err_ctrl; // Enables and loopback bits of error register
    reg err_type; // Last data error kind, setup when high

    // Decoded access strobes
    wire wr_aux1_hi = reg_wr_in && (reg_addr_in == `AUX1_CTRL_HIGH_ADDR);
    wire wr_gain_lo = reg_wr_in && (reg_addr_in == `QUAD_GAIN_LOW_ADDR);
    wire wr_gain_hi = reg_wr_in && (reg_addr_in == `QUAD_GAIN_HIGH_ADDR);
    wire wr_aux2_lo = reg_wr_in && (reg_addr_in == `AUX2_DATA_LOW_ADDR);
    wire wr_aux2_hi = reg_wr_in && (reg_addr_in == `AUX2_CTRL_HIGH_ADDR);
    wire wr_err = reg_wr_in && (reg_addr_in == `TIMING_ERR_ADDR);
    wire rd_err = reg_rd_in && (reg_addr_in == `TIMING_ERR_ADDR);

    // Latched flags: bit 1 data port, bit 0 sync input
    wire [1:0] err_set = {data_timing_err_in, sync_timing_err_in};
    wire [1:0] err_flag;

    // One sticky latch per error source
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_err
            sticky_flag u_flag (
                .clk_in(ref_clk_in),
                .rstn_in(rstn_in),
                .set_in(err_set[g]),
                .clear_in(rd_err),
                .flag_out(err_flag[g])
            );
        end
    endgenerate

    // Full read image of the error register, built from live state
    wire [7:0] err_image = {err_flag[1], err_flag[0], 1'b0, err_type,
        err_ctrl[3:0]};

    // Register writes; masks drop bits that carry no field
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            aux_current1_ctrl_high <= `AUX1_CTRL_HIGH_RST;
            quad_gain_low <= `QUAD_GAIN_LOW_RST;
            quad_gain_high_power <= `QUAD_GAIN_HIGH_RST;
            aux_current2_data_low <= `AUX2_DATA_LOW_RST;
            aux_current2_ctrl_high <= `AUX2_CTRL_HIGH_RST;
            err_ctrl <= `TIMING_ERR_RST;
        end else begin
            if (wr_aux1_hi) begin
                aux_current1_ctrl_high <= reg_wdata_in & `AUX_CTRL_HIGH_MASK;
            end
            if (wr_gain_lo) begin
                quad_gain_low <= reg_wdata_in;
            end
            if (wr_gain_hi) begin
                quad_gain_high_power <= reg_wdata_in & `QUAD_GAIN_HIGH_MASK;
            end
            if (wr_aux2_lo) begin
                aux_current2_data_low <= reg_wdata_in;
            end
            if (wr_aux2_hi) begin
                aux_current2_ctrl_high <= reg_wdata_in & `AUX_CTRL_HIGH_MASK;
            end
            // Flags and type bit are read-only; only enables and loopback store
            if (wr_err) begin
                err_ctrl <= reg_wdata_in & `TIMING_ERR_WMASK;
            end
        end
    end

    // Error kind follows each data port violation; left alone otherwise
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            err_type <= 1'b0;
        end else if (data_timing_err_in) begin
            err_type <= data_err_setup_in;
        end
    end

    // Read data; captured on the same edge that clears the flags
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `AUX1_CTRL_HIGH_ADDR: begin
                    reg_rdata_out <= aux_current1_ctrl_high;
                end
                `QUAD_GAIN_LOW_ADDR: begin
                    reg_rdata_out <= quad_gain_low;
                end
                `QUAD_GAIN_HIGH_ADDR: begin
                    reg_rdata_out <= quad_gain_high_power;
                end
                `AUX2_DATA_LOW_ADDR: begin
                    reg_rdata_out <= aux_current2_data_low;
                end
                `AUX2_CTRL_HIGH_ADDR: begin
                    reg_rdata_out <= aux_current2_ctrl_high;
                end
                `TIMING_ERR_ADDR: begin
                    reg_rdata_out <= err_image;
                end
                // Reserved and foreign offsets read zero
                default: begin
                    reg_rdata_out <= 8'h00;
                end
            endcase
        end
    end

    // Aux2 ten-bit word, bit 9 most significant
    wire [DATA_WIDTH-1:0] aux2_word = {aux_current2_ctrl_high[`DATA_HI_MSB:0],
        aux_current2_data_low};
    // Aux2 runs unless powered down
    wire aux2_on = ~aux_current2_ctrl_high[`AUX_PD_BIT];

    // Analog-side controls; one cycle behind the register image so that
    // every output comes from a flop
    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            quad_gain_out <= {DATA_WIDTH{1'b0}};
            quad_sleep_out <= 1'b0;
            quad_pd_out <= 1'b0;
            aux1_data_high_out <= 2'b00;
            aux1_pos_out <= 1'b0;
            aux1_neg_out <= 1'b0;
            aux1_sink_out <= 1'b0;
            aux1_pd_out <= 1'b0;
            aux2_pos_out <= {DATA_WIDTH{1'b0}};
            aux2_neg_out <= {DATA_WIDTH{1'b0}};
            aux2_sink_out <= 1'b0;
            aux2_pd_out <= 1'b0;
            sync_loopback_out <= 1'b0;
            timing_irq_out <= 1'b0;
        end else begin
            // Gain word split across two registers
            quad_gain_out <= {quad_gain_high_power[`DATA_HI_MSB:0],
                quad_gain_low};
            quad_sleep_out <= quad_gain_high_power[`QUAD_SLEEP_BIT];
            quad_pd_out <= quad_gain_high_power[`QUAD_PD_BIT];
            // Aux1 low data byte lives outside this bank; only its top bits here
            aux1_data_high_out <= aux_current1_ctrl_high[`DATA_HI_MSB:0];
            // Active-pin select, gated off while powered down
            aux1_pos_out <= ~aux_current1_ctrl_high[`AUX_PD_BIT]
                & ~aux_current1_ctrl_high[`AUX_SIGN_BIT];
            aux1_neg_out <= ~aux_current1_ctrl_high[`AUX_PD_BIT]
                & aux_current1_ctrl_high[`AUX_SIGN_BIT];
            aux1_sink_out <= aux_current1_ctrl_high[`AUX_DIR_BIT];
            aux1_pd_out <= aux_current1_ctrl_high[`AUX_PD_BIT];
            // Plain binary magnitude keeps the current monotonic in the word
            if (aux2_on && !aux_current2_ctrl_high[`AUX_SIGN_BIT]) begin
                aux2_pos_out <= aux2_word;
                aux2_neg_out <= {DATA_WIDTH{1'b0}};
            end else if (aux2_on) begin
                aux2_pos_out <= {DATA_WIDTH{1'b0}};
                aux2_neg_out <= aux2_word;
            end else begin
                // Powered down: both pins idle
                aux2_pos_out <= {DATA_WIDTH{1'b0}};
                aux2_neg_out <= {DATA_WIDTH{1'b0}};
            end
            aux2_sink_out <= aux_current2_ctrl_high[`AUX_DIR_BIT];
            aux2_pd_out <= aux_current2_ctrl_high[`AUX_PD_BIT];
            sync_loopback_out <= err_ctrl[`SYNC_LOOP_BIT];
            // Masked flags still latch; only the request line is gated
            timing_irq_out <= (err_flag[1] & err_ctrl[`ERR_DATA_EN_BIT])
                | (err_flag[0] & err_ctrl[`ERR_SYNC_EN_BIT]);
        end
    end

endmodule // dac_aux_gain_irq_regs

// File: test/dac_aux_regs_sva.sv
// Port checker for the aux/gain/error register bank.
// Assumes binding onto dac_aux_gain_irq_regs.
`timescale 1ns/1ps
module dac_aux_regs_sva #(
    parameter DATA_WIDTH = 10
) (
    input wire ref_clk_in,
    input wire rstn_in,
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire data_timing_err_in,
    input wire sync_timing_err_in,
    input wire [7:0] reg_rdata_out,
    input wire [DATA_WIDTH-1:0] quad_gain_out,
    input wire aux1_pos_out,
    input wire aux1_sink_out,
    input wire aux1_pd_out,
    input wire [DATA_WIDTH-1:0] aux2_pos_out,
    input wire [DATA_WIDTH-1:0] aux2_neg_out,
    input wire aux2_pd_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    // Read of the error register, and no event in flight
    wire rd_err = reg_rd_in && reg_addr_in == 8'h19;
    wire quiet = !data_timing_err_in && !sync_timing_err_in;
    wire w_aux1 = reg_wr_in && reg_addr_in == 8'h0e;
    a_aux1_sign_pin: assert property (w_aux1 |-> ##2 aux1_pos_out ==
        (!$past(reg_wdata_in[7], 2) && !$past(reg_wdata_in[5], 2))) else $error("aux1 pin");
    a_aux1_dir: assert property (w_aux1 |-> ##2
        aux1_sink_out == $past(reg_wdata_in[6], 2)) else $error("aux1 direction");
    a_aux1_off: assert property (w_aux1 |-> ##2
        aux1_pd_out == $past(reg_wdata_in[5], 2)) else $error("aux1 power-down");
    a_quad_gain_low: assert property (reg_wr_in && reg_addr_in == 8'h0f |-> ##2
        quad_gain_out[7:0] == $past(reg_wdata_in, 2)) else $error("gain low byte");
    a_aux2_off_zero: assert property (aux2_pd_out |->
        aux2_pos_out == '0 && aux2_neg_out == '0) else $error("aux2 off drives");
    a_data_flag_set: assert property (rd_err && $past(data_timing_err_in)
        && $past(rstn_in) |=> reg_rdata_out[7]) else $error("data flag missing");
    a_sync_flag_set: assert property (rd_err && $past(sync_timing_err_in)
        && $past(rstn_in) |=> reg_rdata_out[6]) else $error("sync flag missing");
    a_read_clears: assert property (rd_err && quiet ##1 quiet ##1 rd_err && quiet
        |=> reg_rdata_out[7:6] == 2'b00) else $error("flags not cleared");
    a_set_beats_clear: assert property (rd_err && data_timing_err_in
        ##1 !rd_err ##1 rd_err |=> reg_rdata_out[7]) else $error("set lost to clear");
    a_unmapped_zero: assert property (reg_rd_in &&
        !(reg_addr_in inside {[8'h0e:8'h12], 8'h19}) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
endmodule // dac_aux_regs_sva
bind dac_aux_gain_irq_regs dac_aux_regs_sva #(.DATA_WIDTH(DATA_WIDTH)) dac_aux_regs_sva_i (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .data_timing_err_in(data_timing_err_in), .sync_timing_err_in(sync_timing_err_in),
    .reg_rdata_out(reg_rdata_out), .quad_gain_out(quad_gain_out), .aux1_pos_out(aux1_pos_out),
    .aux1_sink_out(aux1_sink_out), .aux1_pd_out(aux1_pd_out), .aux2_pos_out(aux2_pos_out),
    .aux2_neg_out(aux2_neg_out), .aux2_pd_out(aux2_pd_out));

// File: test/dac_aux_gain_irq_regs_tb_top.sv
// Self-checking bench for the aux/gain/error register bank.
// Assumes the strobe register port and error inputs at the block's pins.
`timescale 1ns/1ps
module dac_aux_gain_irq_regs_tb_top;
    reg ref_clk_in = 1'b0;
    reg rstn_in = 1'b0;
    reg [7:0] reg_addr_in = 8'h00;
    reg [7:0] reg_wdata_in = 8'h00;
    reg reg_wr_in = 1'b0;
    reg reg_rd_in = 1'b0;
    reg data_timing_err_in = 1'b0;
    reg data_err_setup_in = 1'b0;
    reg sync_timing_err_in = 1'b0;
    wire [7:0] reg_rdata_out;
    wire [9:0] quad_gain_out, aux2_pos_out, aux2_neg_out;
    wire [1:0] aux1_data_high_out;
    wire quad_sleep_out, quad_pd_out, aux1_pos_out, aux1_neg_out, aux1_sink_out, aux1_pd_out;
    wire aux2_sink_out, aux2_pd_out, sync_loopback_out, timing_irq_out;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    // Rows: offset, write value, read-back, reset value
    logic [31:0] rows [8] = '{32'h0effe300, 32'h0fa5a5fc, 32'h10ffc301, 32'h113c3c00,
        32'h12ffe300, 32'h19ff0d00, 32'h13ff0000, 32'h1fff0000};
    dac_aux_gain_irq_regs dac_aux_gain_irq_regs_i (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .data_timing_err_in(data_timing_err_in),
        .data_err_setup_in(data_err_setup_in), .sync_timing_err_in(sync_timing_err_in),
        .reg_rdata_out(reg_rdata_out), .quad_gain_out(quad_gain_out),
        .quad_sleep_out(quad_sleep_out), .quad_pd_out(quad_pd_out),
        .aux1_data_high_out(aux1_data_high_out), .aux1_pos_out(aux1_pos_out),
        .aux1_neg_out(aux1_neg_out), .aux1_sink_out(aux1_sink_out), .aux1_pd_out(aux1_pd_out),
        .aux2_pos_out(aux2_pos_out), .aux2_neg_out(aux2_neg_out), .aux2_sink_out(aux2_sink_out),
        .aux2_pd_out(aux2_pd_out), .sync_loopback_out(sync_loopback_out),
        .timing_irq_out(timing_irq_out));
    always #2.5 ref_clk_in = ~ref_clk_in;
    task automatic tick;
        @(posedge ref_clk_in);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Strobe held one edge, then a quiet edge so strobes never toggle twice at once
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        tick;
        reg_wr_in = 1'b0;
        tick;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        tick;
        reg_rd_in = 1'b0;
        chk_val({2'b00, reg_rdata_out}, {2'b00, e});
        tick;
    endtask
    // Hang guard, far above the roughly 110 cycles used
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk_in);
        #1 rstn_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            wr_reg(rows[i][31:24], rows[i][23:16]);
            rd_chk(rows[i][31:24], rows[i][15:8]);
        end
        chk_val(quad_gain_out, 10'h3a5);
        // Sleep, power-down, aux1 top bits and loopback all written high by the rows
        chk_val({5'h00, quad_sleep_out, quad_pd_out, aux1_data_high_out, sync_loopback_out}, 10'h01f);
        rstn_in = 1'b0;
        tick;
        rstn_in = 1'b1;
        for (int i = 0; i < 8; i++) rd_chk(rows[i][31:24], rows[i][7:0]);
        chk_val(quad_gain_out, 10'h1fc);
        chk_val({5'h00, quad_sleep_out, quad_pd_out, aux1_data_high_out, sync_loopback_out}, 10'h000);
        wr_reg(8'h0e, 8'h80);
        chk_val({6'h00, aux1_pos_out, aux1_neg_out, aux1_sink_out, aux1_pd_out}, 10'h004);
        wr_reg(8'h0e, 8'h40);
        chk_val({6'h00, aux1_pos_out, aux1_neg_out, aux1_sink_out, aux1_pd_out}, 10'h00a);
        wr_reg(8'h0e, 8'h60);
        chk_val({6'h00, aux1_pos_out, aux1_neg_out, aux1_sink_out, aux1_pd_out}, 10'h003);
        wr_reg(8'h11, 8'h34);
        wr_reg(8'h12, 8'h82);
        chk_val(aux2_neg_out, 10'h234);
        chk_val(aux2_pos_out, 10'h000);
        wr_reg(8'h12, 8'h02);
        chk_val(aux2_pos_out, 10'h234);
        wr_reg(8'h12, 8'h62);
        chk_val({8'h00, aux2_sink_out, aux2_pd_out}, 10'h003);
        chk_val(aux2_pos_out | aux2_neg_out, 10'h000);
        wr_reg(8'h19, 8'h08);
        data_err_setup_in = 1'b1;
        data_timing_err_in = 1'b1;
        tick;
        data_timing_err_in = 1'b0;
        repeat (3) tick;
        chk_val({9'h000, timing_irq_out}, 10'h001);
        rd_chk(8'h19, 8'h98);
        rd_chk(8'h19, 8'h18);
        chk_val({9'h000, timing_irq_out}, 10'h000);
        wr_reg(8'h19, 8'h00);
        sync_timing_err_in = 1'b1;
        tick;
        sync_timing_err_in = 1'b0;
        repeat (3) tick;
        chk_val({9'h000, timing_irq_out}, 10'h000);
        wr_reg(8'h19, 8'h04);
        chk_val({9'h000, timing_irq_out}, 10'h001);
        rd_chk(8'h19, 8'h54);
        data_err_setup_in = 1'b0;
        data_timing_err_in = 1'b1;
        sync_timing_err_in = 1'b1;
        tick;
        data_timing_err_in = 1'b0;
        sync_timing_err_in = 1'b0;
        rd_chk(8'h19, 8'hc4);
        // Event in the very cycle of a clearing read: the set must survive it
        data_timing_err_in = 1'b1;
        reg_addr_in = 8'h19;
        reg_rd_in = 1'b1;
        tick;
        data_timing_err_in = 1'b0;
        reg_rd_in = 1'b0;
        chk_val({2'b00, reg_rdata_out}, 10'h004);
        tick;
        rd_chk(8'h19, 8'h84);
        tally_and_finish;
    end
endmodule // dac_aux_gain_irq_regs_tb_top
